// [design/emb_pkg.sv]
// package: constants for the external memory bus interface
package emb_pkg;
  // address map of the data space
  localparam logic [15:0] NVM_LAST   = 16'h01ff;
  localparam logic [15:0] RAM_FIRST  = 16'h0200;
  localparam logic [15:0] RAM_LAST   = 16'h02ff;
  // start vector locations in program space
  localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0001;
  // general port lines
  localparam int          PORT_LINES = 40;
  localparam logic [39:0] PORT_SEL_RST = 40'h00_0000_0000;
  // strobe phase lengths in cycles
  localparam logic [1:0]  ADDR_CYC = 2'h1;
  localparam logic [1:0]  DATA_CYC = 2'h2;
  // bus cycle phases
  typedef enum logic [2:0] {
    EMB_IDLE, EMB_ADDR, EMB_LATCH, EMB_DATA, EMB_END
  } emb_state_t;
endpackage : emb_pkg

// [design/emb_port_mux.sv]
// file: per-line general port / alternate function selector
`timescale 1ns/1ps
module emb_port_mux (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [39:0] alt_sel,
  input  wire logic [39:0] gpio_out,
  input  wire logic [39:0] gpio_oe,
  input  wire logic [39:0] alt_out,
  input  wire logic [39:0] alt_oe,
  output logic      [39:0] port_out,
  output logic      [39:0] port_oe
);
  // ==========================================================
  // selection per line
  logic [39:0] next_out;
  logic [39:0] next_oe;
  for (genvar i = 0; i < emb_pkg::PORT_LINES; i++) begin : g_line
    assign next_out[i] = alt_sel[i] ? alt_out[i] : gpio_out[i];
    assign next_oe[i]  = alt_sel[i] ? alt_oe[i]  : gpio_oe[i];
  end
  // registered so pins come straight from flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_out <= emb_pkg::PORT_SEL_RST;
      port_oe  <= emb_pkg::PORT_SEL_RST;
    end else begin
      port_out <= next_out;
      port_oe  <= next_oe;
    end
  end
endmodule : emb_port_mux

// [design/emb_bus_if.sv]
// file: external memory bus sequencer
`timescale 1ns/1ps
module emb_bus_if (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_prog,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  output logic             rsp_internal,
  output logic             boot_done,
  output logic [15:0]      start_addr,
  input  wire logic        bus_float,
  input  wire logic        wait_in,
  output logic             address_strobe_n,
  output logic             data_strobe_n,
  output logic             read_write,
  output logic             ctl_oe,
  output logic [7:0]       muxed_addr_data_bus_out,
  input  wire logic [7:0]  muxed_addr_data_bus_in,
  output logic             muxed_addr_data_bus_oe,
  output logic [7:0]       upper_address_bus,
  output logic             upper_address_oe,
  output logic             space_is_prog,
  input  wire logic [39:0] alt_sel,
  input  wire logic [39:0] gpio_out,
  input  wire logic [39:0] gpio_oe,
  input  wire logic [39:0] alt_out,
  input  wire logic [39:0] alt_oe,
  output logic      [39:0] port_out,
  output logic      [39:0] port_oe
);
  // ==========================================================
  // state
  emb_pkg::emb_state_t state;
  emb_pkg::emb_state_t next_state;
  logic [1:0]  cnt;
  logic        boot_phase;   // 0 high byte, 1 low byte
  logic        cur_prog;
  logic        cur_write;
  logic        cur_int;
  logic [15:0] cur_addr;
  logic [7:0]  cur_wdata;

  // ==========================================================
  // decode
  // internal data windows
  wire in_nvm   = req_addr <= emb_pkg::NVM_LAST;
  wire in_ram   = req_addr >= emb_pkg::RAM_FIRST && req_addr <= emb_pkg::RAM_LAST;
  wire is_int   = !req_prog && (in_nvm || in_ram);
  // start vector fetch precedes any user request
  wire boot_go  = !boot_done;
  wire take     = (state == emb_pkg::EMB_IDLE) && (boot_go || req_valid);
  wire [15:0] take_addr = boot_go ? (boot_phase ? emb_pkg::VEC_LO_ADDR
                                                : emb_pkg::VEC_HI_ADDR) : req_addr;
  wire take_prog  = boot_go | req_prog;
  wire take_write = !boot_go & req_write;
  wire take_int   = !boot_go & is_int;
  wire cnt_done   = cnt == 2'h0;

  // next state; wait only holds the data phase
  always_comb begin
    next_state = state;
    unique case (state)
      emb_pkg::EMB_IDLE:  if (take) next_state = emb_pkg::EMB_ADDR;
      emb_pkg::EMB_ADDR:  if (cnt_done) next_state = emb_pkg::EMB_LATCH;
      emb_pkg::EMB_LATCH: next_state = emb_pkg::EMB_DATA;
      emb_pkg::EMB_DATA:  if (cnt_done && !wait_in) next_state = emb_pkg::EMB_END;
      emb_pkg::EMB_END:   next_state = emb_pkg::EMB_IDLE;
    endcase
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= emb_pkg::EMB_IDLE;
      cnt <= 2'h0;
      cur_prog <= 1'b1;
      cur_write <= 1'b0;
      cur_int <= 1'b0;
      cur_addr <= 16'h0000;
      cur_wdata <= 8'h00;
    end else begin
      state <= next_state;
      if (take) begin
        cnt <= emb_pkg::ADDR_CYC - 2'h1;
        cur_prog <= take_prog;
        cur_write <= take_write;
        cur_int <= take_int;
        cur_addr <= take_addr;
        cur_wdata <= req_wdata;
      end else if (state == emb_pkg::EMB_LATCH) begin
        cnt <= emb_pkg::DATA_CYC - 2'h1;
      end else if (!cnt_done) begin
        cnt <= cnt - 2'h1;
      end
    end
  end

  // boot vector and answers
  wire fin = state == emb_pkg::EMB_END;
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_done <= 1'b0;
      boot_phase <= 1'b0;
      start_addr <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_internal <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      rsp_valid <= fin && boot_done;
      rsp_internal <= cur_int;
      req_ready <= boot_done && (next_state == emb_pkg::EMB_IDLE) && !take;
      // sample read data at data strobe rise
      if (state == emb_pkg::EMB_DATA && next_state == emb_pkg::EMB_END && !cur_write)
        rsp_rdata <= muxed_addr_data_bus_in;
      if (fin && !boot_done) begin
        if (boot_phase) begin
          start_addr[7:0] <= rsp_rdata;
          boot_done <= 1'b1;
        end else begin
          start_addr[15:8] <= rsp_rdata;
        end
        boot_phase <= ~boot_phase;
      end
    end
  end

  // ==========================================================
  // pin drive
  // strobe low only in address phase
  wire next_as_n = !(next_state == emb_pkg::EMB_ADDR);
  // no data strobe for internal data
  wire next_ds_n = !((next_state == emb_pkg::EMB_DATA) && !(take ? take_int : cur_int));
  wire busy      = next_state != emb_pkg::EMB_IDLE;
  wire [15:0] next_addr  = take ? take_addr : cur_addr;
  wire        next_wr    = take ? take_write : cur_write;
  wire        next_prog  = take ? take_prog : cur_prog;
  // address byte then data byte on shared lines
  wire addr_ph = (next_state == emb_pkg::EMB_ADDR) || (next_state == emb_pkg::EMB_LATCH);
  wire [7:0] next_ad = addr_ph ? next_addr[7:0] : cur_wdata;
  // write data launched on the edge that drops the data strobe
  // the address stays through the latch phase so memory holds it at the strobe rise
  wire next_ad_oe = !bus_float && busy && (addr_ph || next_wr);
  always_ff @(posedge mclk) begin
    if (rst) begin
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      read_write <= 1'b1;
      ctl_oe <= 1'b1;
      muxed_addr_data_bus_out <= 8'h00;
      muxed_addr_data_bus_oe <= 1'b0;
      upper_address_bus <= 8'h00;
      upper_address_oe <= 1'b1;
      space_is_prog <= 1'b1;
    end else begin
      address_strobe_n <= next_as_n;
      data_strobe_n <= next_ds_n;
      // direction and space held from address phase
      read_write <= busy ? !next_wr : 1'b1;
      space_is_prog <= next_prog;
      // software float of all bus pins
      ctl_oe <= !bus_float;
      upper_address_oe <= !bus_float;
      // upper byte held for whole cycle
      upper_address_bus <= next_addr[15:8];
      muxed_addr_data_bus_out <= next_ad;
      muxed_addr_data_bus_oe <= next_ad_oe;
    end
  end

  // general port lines
  emb_port_mux u_ports (
    .mclk     (mclk),
    .rst      (rst),
    .alt_sel  (alt_sel),
    .gpio_out (gpio_out),
    .gpio_oe  (gpio_oe),
    .alt_out  (alt_out),
    .alt_oe   (alt_oe),
    .port_out (port_out),
    .port_oe  (port_oe)
  );

  // ==========================================================
  // checks
  // single low cycle of address strobe
  as_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(address_strobe_n) |=> $rose(address_strobe_n)) else $error("as not one cycle");
  // internal data keeps data strobe high
  ds_int_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_int && state != emb_pkg::EMB_IDLE) |-> data_strobe_n) else $error("ds on internal");
  rw_wr_a: assert property (@(posedge mclk) disable iff (rst)
    (!data_strobe_n && cur_write) |-> !read_write) else $error("rw not low on write");
  // data driven while strobe low on write
  wr_data_a: assert property (@(posedge mclk) disable iff (rst || bus_float)
    (!data_strobe_n && cur_write) |-> muxed_addr_data_bus_oe
    && muxed_addr_data_bus_out == cur_wdata) else $error("write data absent");
  addr_hold_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(address_strobe_n) |-> $stable(upper_address_bus)) else $error("addr moved");
  // float removes drive one cycle later
  bus_float_a: assert property (@(posedge mclk) disable iff (rst)
    bus_float |=> !ctl_oe && !muxed_addr_data_bus_oe && !upper_address_oe)
    else $error("bus not floated");
  wait_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state == emb_pkg::EMB_DATA && wait_in) |=> state == emb_pkg::EMB_DATA)
    else $error("wait ignored");
  boot_fetch_a: assert property (@(posedge mclk) disable iff (rst)
    (!boot_done && $fell(address_strobe_n)) |-> space_is_prog && read_write)
    else $error("boot fetch wrong");
  prog_ext_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_prog && state == emb_pkg::EMB_DATA) |-> !data_strobe_n) else $error("prog internal");
  boot_c:  cover property (@(posedge mclk) $rose(boot_done));
  write_c: cover property (@(posedge mclk) !data_strobe_n && !read_write);
  int_c:   cover property (@(posedge mclk) rsp_valid && rsp_internal);
  wait_c:  cover property (@(posedge mclk) state == emb_pkg::EMB_DATA && wait_in);
endmodule : emb_bus_if

// [testbench/emb_mem_model.sv]
// file: behavioural external program and data memory on the bus
`timescale 1ns/1ps
module emb_mem_model (
  input  wire logic        mclk,
  input  wire logic        address_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        read_write,
  input  wire logic        space_is_prog,
  input  wire logic [7:0]  upper_address_bus,
  input  wire logic [7:0]  ad_out,
  input  wire logic        ad_oe,
  input  wire logic        slow,
  output logic             wait_in,
  output logic      [7:0]  ad_in,
  output logic      [15:0] lat_addr,
  output logic             lat_prog,
  output logic             lat_rw
);
  logic [7:0]  mem [logic [16:0]];
  logic [7:0]  last = 8'h00;
  logic [7:0]  rd;
  logic [1:0]  wcnt = 2'h0;
  logic [16:0] k;
  // ==========================================
  // latch the cycle while the address strobe is low
  always @(posedge mclk) begin
    if (!address_strobe_n) begin
      lat_addr <= {upper_address_bus, ad_out};
      lat_prog <= space_is_prog;
      lat_rw <= read_write;
    end
    if (!data_strobe_n && !read_write) begin
      mem[k] = ad_out;
    end
    wcnt <= data_strobe_n ? 2'h0 : (wcnt == 2'h3 ? wcnt : wcnt + 2'h1);
    last <= ad_in;
  end
  assign k = {lat_prog, lat_addr};
  // unwritten places hold a fixed address pattern
  always @* begin
    rd = mem.exists(k) ? mem[k] : (lat_addr[7:0] ^ lat_addr[15:8] ^ 8'h5a);
  end
  // read data driven
  // released lines toggle, so a late sample never reads stale data
  assign ad_in = ad_oe ? ad_out : ((!data_strobe_n && read_write) ? rd : ~last);
  assign wait_in = slow && !data_strobe_n && (wcnt < 2'h2);
endmodule : emb_mem_model

// [testbench/external_memory_bus_interface_tb.sv]
// file: self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
module external_memory_bus_interface_tb;
  typedef struct packed {
    logic [7:0] d; logic intl; logic chk; logic [15:0] a; logic p; logic w;
  } emb_note_t;
  logic mclk, rst, req_valid, req_prog, req_write, bus_float, wait_in, slow, prev_as;
  logic [15:0] req_addr, start_addr, lat_addr;
  logic [7:0] req_wdata, rsp_rdata, muxed_addr_data_bus_out, muxed_addr_data_bus_in;
  logic [7:0] upper_address_bus;
  logic req_ready, rsp_valid, rsp_internal, boot_done, address_strobe_n, data_strobe_n;
  logic read_write, ctl_oe, muxed_addr_data_bus_oe, upper_address_oe, space_is_prog;
  logic lat_prog, lat_rw;
  logic [39:0] alt_sel, gpio_out, gpio_oe, alt_out, alt_oe, port_out, port_oe;
  int bad_count, compares, t, falls, lows;
  logic [31:0] seed, r;
  logic [7:0] shadow [logic [16:0]];
  emb_note_t notes [$];
  emb_note_t n;
  logic [15:0] probe [6] = '{16'h0000, 16'h01ff, 16'h0200, 16'h02ff, 16'h0300, 16'hffff};
  emb_bus_if dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_prog(req_prog),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_internal(rsp_internal),
    .boot_done(boot_done), .start_addr(start_addr), .bus_float(bus_float), .wait_in(wait_in),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .read_write(read_write), .ctl_oe(ctl_oe),
    .muxed_addr_data_bus_out(muxed_addr_data_bus_out),
    .muxed_addr_data_bus_in(muxed_addr_data_bus_in),
    .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe),
    .upper_address_bus(upper_address_bus), .upper_address_oe(upper_address_oe),
    .space_is_prog(space_is_prog), .alt_sel(alt_sel), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .alt_out(alt_out), .alt_oe(alt_oe), .port_out(port_out),
    .port_oe(port_oe));
  emb_mem_model mdl (.mclk(mclk), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .space_is_prog(space_is_prog),
    .upper_address_bus(upper_address_bus), .ad_out(muxed_addr_data_bus_out),
    .ad_oe(muxed_addr_data_bus_oe), .slow(slow), .wait_in(wait_in),
    .ad_in(muxed_addr_data_bus_in), .lat_addr(lat_addr), .lat_prog(lat_prog), .lat_rw(lat_rw));
  // ==========================================
  // clock and watchdog
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // note the expectation, then hold the request until the response pulse
  task automatic do_req(input logic p, input logic w, input logic [15:0] a, input logic [7:0] d);
    emb_note_t m;
    m.intl = !p && a <= emb_pkg::RAM_LAST;
    m.d = shadow.exists({p, a}) ? shadow[{p, a}] : (a[7:0] ^ a[15:8] ^ 8'h5a);
    m.chk = !w && !m.intl;
    m.a = a;
    m.p = p;
    m.w = w;
    if (w && !m.intl) shadow[{p, a}] = d;
    notes.push_back(m);
    {req_valid, req_prog, req_write, req_addr, req_wdata} = {1'b1, p, w, a, d};
    t = 0;
    do begin
      @(posedge mclk);
      #1 t++;
    end while (!rsp_valid && t < 100);
    chk(rsp_valid, 1'b1, "response in time");
  endtask : do_req
  // ==========================================
  // response monitor: strobe counts and oldest note
  // sampled mid-cycle so registered outputs have settled
  always @(negedge mclk) begin
    if (!boot_done) {falls, lows} = 0;
    else begin
      if (prev_as && !address_strobe_n) falls++;
      if (!data_strobe_n) lows++;
      if (!address_strobe_n) chk(req_ready, 1'b0, "ready while busy");
      if (!data_strobe_n) chk(upper_address_bus, lat_addr[15:8], "upper byte held");
      if (rsp_valid && notes.size() == 0) chk(rsp_valid, 1'b0, "stray response");
      else if (rsp_valid) begin
        n = notes.pop_front();
        chk(falls, 1, "address strobe count");
        chk(req_ready, 1'b1, "ready after cycle");
        chk(lows == 0, n.intl, "data strobe on-chip");
        chk(lat_addr, n.a, "latched address");
        chk(lat_prog, n.p, "space select");
        chk(lat_rw, !n.w, "direction");
        chk(rsp_internal, n.intl, "on-chip decode");
        if (n.chk) chk(rsp_rdata, n.d, "read data");
        {falls, lows} = 0;
      end
    end
    prev_as = address_strobe_n;
  end
  // ==========================================
  // main sequence
  initial begin
    {rst, seed, slow, bus_float} = {1'b1, 32'd78999, 2'b00};
    {req_valid, req_prog, req_write, req_addr, req_wdata} = 0;
    {alt_sel, gpio_out, gpio_oe, alt_out, alt_oe} = 0;
    repeat (6) @(posedge mclk);
    #1 rst = 0;
    t = 0;
    while (!boot_done && t < 200) begin
      @(posedge mclk);
      #1 t++;
    end
    chk(boot_done, 1'b1, "boot finished");
    chk(start_addr, 16'h5a5b, "start vector");
    foreach (probe[i]) begin
      do_req(1'b0, 1'b1, probe[i], 8'h3c ^ 8'(i));
      do_req(1'b0, 1'b0, probe[i], 8'h00);
    end
    for (int j = 0; j < 40; j++) begin
      r = rnd();
      slow = j < 20;
      do_req(r[17], r[16], r[18] ? r[15:0] : {12'h030, r[3:0]}, r[31:24]);
    end
    do_req(1'b1, 1'b0, 16'h8000, 8'h00);
    req_valid = 0;
    bus_float = 1;
    repeat (2) @(posedge mclk);
    #1 chk({ctl_oe, muxed_addr_data_bus_oe, upper_address_oe}, 3'h0, "float");
    bus_float = 0;
    repeat (2) @(posedge mclk);
    #1 chk({ctl_oe, upper_address_oe}, 2'h3, "unfloat");
    repeat (8) begin
      {alt_sel, gpio_out, gpio_oe} = 120'({rnd(), rnd(), rnd(), rnd()});
      {alt_out, alt_oe} = 80'({rnd(), rnd(), rnd()});
      @(posedge mclk);
      #1 chk(port_out, (alt_sel & alt_out) | (~alt_sel & gpio_out), "port out");
      chk(port_oe, (alt_sel & alt_oe) | (~alt_sel & gpio_oe), "port oe");
    end
    chk(notes.size(), 0, "responses left");
    finish_test();
  end
endmodule : external_memory_bus_interface_tb
